// [logic/rpsel_pkg.sv]
package rpsel_pkg;
   // ==========================================================
   // Register map
   // ==========================================================
   localparam int ADDR_W = 10;
   localparam logic [9:0] IN_SEL_BASE = 10'h000;
   localparam logic [9:0] OUT_SEL_BASE = 10'h080;
   localparam logic [9:0] CFG_CTRL_OFS = 10'h100;
   localparam logic [9:0] UNLOCK_OFS = 10'h104;
   localparam int NUM_IN_SEL = 24;
   localparam int NUM_PINS = 32;
   localparam int GROUP_PINS = 8;
   localparam int SEL_W = 4;
   localparam int LOCK_BIT = 13;
   localparam int ONE_WAY_BIT = 29;
   localparam int ARMED_BIT = 0;
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic LOCK_RESET = 1'b0;
   // Arbitrary unlock keys
   localparam logic [31:0] UNLOCK_KEY_A = 32'h5A5A_1234;
   localparam logic [31:0] UNLOCK_KEY_B = 32'hA5A5_4321;

   // ==========================================================
   // Pin presence, indexed group*8 + input code
   // ==========================================================
   localparam logic [31:0] PIN44_ONLY_MASK = 32'hE0E0_E0E0;
   localparam logic [31:0] NON_USB_MASK = 32'h0802_0800;
   localparam logic [31:0] NO_OUT_REG_MASK = 32'h0004_0004;

   // ==========================================================
   // Output codes
   // ==========================================================
   localparam logic [3:0] OC_NONE = 4'h0;
   localparam logic [3:0] G1_UART2_RTS = 4'h2;
   localparam logic [3:0] G1_SPI1_SEL = 4'h3;
   localparam logic [3:0] G1_BUS_PWR = 4'h4;
   localparam logic [3:0] G1_CMP1 = 4'h5;
   localparam logic [3:0] G1_COMPARATOR2 = 4'h7;
   localparam logic [3:0] G2_SPI1_DO = 4'h3;
   localparam logic [3:0] G2_SPI2_DO = 4'h4;
   localparam logic [3:0] G2_CMP2 = 4'h5;
   localparam logic [3:0] G2_COMPARATOR3 = 4'h7;
   localparam logic [3:0] G3_SPI1_DO = 4'h3;
   localparam logic [3:0] G3_SPI2_DO = 4'h4;
   localparam logic [3:0] G3_CMP4 = 4'h5;
   localparam logic [3:0] G3_CMP5 = 4'h6;
   localparam logic [3:0] G3_REFCLK = 4'h7;
   localparam logic [3:0] G4_UART1_RTS = 4'h1;
   localparam logic [3:0] G4_UART2_TX = 4'h2;
   localparam logic [3:0] G4_SPI2_SEL = 4'h4;
   localparam logic [3:0] G4_CMP3 = 4'h5;
   localparam logic [3:0] G4_COMPARATOR1 = 4'h7;

   typedef enum logic [1:0] {UL_IDLE, UL_KEY_A, UL_ARMED} rpsel_unlock_t;

   // Input selector index to its pin group
   function automatic logic [1:0] rpsel_in_group(input int idx);
      if (idx < 5) begin
         return 2'h0;
      end else if (idx < 11) begin
         return 2'h1;
      end else if (idx < 19) begin
         return 2'h2;
      end
      return 2'h3;
   endfunction : rpsel_in_group
endpackage : rpsel_pkg

// [logic/rpsel_crossbar.sv]
`timescale 1ns/1ps
// What this block does
// - Each peripheral input has own pin selector
// - Four-bit input code picks that pin number
// - Group one inputs: A0 B3 B4 B15 B7 C7 C0 C5
// - Group two inputs: A1 B5 B1 B11 B8 A8 C8 A9
// - Group three inputs: A2 B6 A4 B13 B2 C6 C1 C3
// - Group four inputs: A3 B14 B0 B10 B9 C9 C2 C4
// - Each pin except 2 and 18 has four-bit output selector
// - Output selectors reset to no connection
// - Group one outputs: RTS, select, bus power, compares
// - Group two outputs: SPI data, compare, comparator
// - Group three outputs: SPI data, compares, reference clock
// - Group four outputs: RTS, transmit, select, compares
// - Locked selector writes accepted but ignored
// - Lock bit 13 blocks selector writes
// - Lock changes need unlock sequence first
// - One-way option keeps lock until reset
// - Unprogrammed one-way option reads as set
// - Input and output routing fully independent
// - Package variant removes absent pins and outputs
// - Remap beats GPIO, never analog
module rpsel_crossbar
   import rpsel_pkg::*;
#(
   parameter bit PIN44 = 1'b1,
   parameter bit USB = 1'b0,
   parameter logic [NUM_IN_SEL-1:0] IN_IDLE_LEVEL = 24'h00_0000
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Device configuration word three, static fuse value
   input wire logic [31:0] DEV_CFG_WORD3,
   // Pins and port logic
   input wire logic [NUM_PINS-1:0] PIN_IN,
   input wire logic [NUM_PINS-1:0] PIN_ANALOG,
   input wire logic [NUM_PINS-1:0] GPIO_OUT,
   input wire logic [NUM_PINS-1:0] GPIO_OE,
   output logic [NUM_PINS-1:0] PIN_OUT,
   output logic [NUM_PINS-1:0] PIN_OE,
   // Peripheral outputs
   input wire logic UART_ONE_REQUEST_TO_SEND,
   input wire logic UART_TWO_REQUEST_TO_SEND,
   input wire logic UART_TWO_TRANSMIT,
   input wire logic SPI_ONE_SELECT_OUT,
   input wire logic SPI_TWO_SELECT_OUT,
   input wire logic SPI_ONE_DATA_OUT,
   input wire logic SPI_TWO_DATA_OUT,
   input wire logic BUS_POWER_ENABLE,
   input wire logic COMPARE_ONE_OUT,
   input wire logic COMPARE_TWO_OUT,
   input wire logic COMPARE_THREE_OUT,
   input wire logic COMPARE_FOUR_OUT,
   input wire logic COMPARE_FIVE_OUT,
   input wire logic COMPARATOR_ONE_OUT,
   input wire logic COMPARATOR_TWO_OUT,
   input wire logic COMPARATOR_THREE_OUT,
   input wire logic REFERENCE_CLOCK_OUT,
   // Peripheral inputs
   output logic EXT_IRQ_FOUR,
   output logic TIMER_TWO_CLOCK_IN,
   output logic CAPTURE_FOUR_IN,
   output logic SPI_ONE_SELECT,
   output logic REFERENCE_CLOCK_IN,
   output logic EXT_IRQ_THREE,
   output logic TIMER_THREE_CLOCK_IN,
   output logic CAPTURE_THREE_IN,
   output logic UART_ONE_CLEAR_TO_SEND,
   output logic UART_TWO_RECEIVE,
   output logic SPI_ONE_DATA_IN,
   output logic EXT_IRQ_TWO,
   output logic TIMER_FOUR_CLOCK_IN,
   output logic CAPTURE_ONE_IN,
   output logic CAPTURE_FIVE_IN,
   output logic UART_ONE_RECEIVE,
   output logic UART_TWO_CLEAR_TO_SEND,
   output logic SPI_TWO_DATA_IN,
   output logic COMPARE_FAULT_B,
   output logic EXT_IRQ_ONE,
   output logic TIMER_FIVE_CLOCK_IN,
   output logic CAPTURE_TWO_IN,
   output logic SPI_TWO_SELECT,
   output logic COMPARE_FAULT_A
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (NUM_PINS != 4 * GROUP_PINS) begin : g_bad_pins
      $error("rpsel_crossbar: pin count must be four groups of eight");
   end
   // Bit 3 of a code marks the reserved half; wider codes need new decode
   if (SEL_W != 4) begin : g_bad_code
      $error("rpsel_crossbar: selector codes must be four bits wide");
   end
   // The peripheral input ports are a fixed list of 24
   if (NUM_IN_SEL != 24) begin : g_bad_inputs
      $error("rpsel_crossbar: peripheral input count must be 24");
   end

   // ==========================================================
   // State
   // ==========================================================
   logic [SEL_W-1:0] in_sel_reg [NUM_IN_SEL];
   logic [SEL_W-1:0] out_sel_reg [NUM_PINS];
   logic lock_reg;
   logic lock_next;
   logic one_way_reg;
   logic ever_locked_reg;
   rpsel_unlock_t unlock_reg;
   logic [NUM_PINS-1:0] pin_meta_reg;
   logic [NUM_PINS-1:0] pin_sync_reg;
   logic [NUM_IN_SEL-1:0] periph_in_reg;
   logic [NUM_IN_SEL-1:0] periph_in_next;
   logic [NUM_PINS-1:0] pin_out_reg;
   logic [NUM_PINS-1:0] pin_oe_reg;
   logic [NUM_PINS-1:0] pin_out_next;
   logic [NUM_PINS-1:0] pin_oe_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [NUM_PINS-1:0] pin_present;
   logic [NUM_PINS-1:0] out_reg_present;
   logic sel_wr_ok;
   logic cfg_wr;
   logic unlock_wr;

   // Package variant: pins that are not bonded out
   assign pin_present = ~((PIN44 ? 32'h0000_0000 : PIN44_ONLY_MASK)
                        | (USB ? NON_USB_MASK : 32'h0000_0000));
   assign out_reg_present = pin_present & ~NO_OUT_REG_MASK;

   assign sel_wr_ok = WR & ~lock_reg;
   assign cfg_wr = WR & (ADDR == CFG_CTRL_OFS);
   assign unlock_wr = WR & (ADDR == UNLOCK_OFS);

   // ==========================================================
   // Pin input synchroniser
   // ==========================================================
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= PIN_IN;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ==========================================================
   // Selector registers
   // ==========================================================
   always_ff @(posedge CORE_CLK) begin
      for (int i = 0; i < NUM_IN_SEL; i++) begin
         if (RESET) begin
            in_sel_reg[i] <= SEL_RESET;
         end else if (sel_wr_ok && ADDR == IN_SEL_BASE + ADDR_W'(4 * i)) begin
            in_sel_reg[i] <= WDATA[SEL_W-1:0];
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      for (int p = 0; p < NUM_PINS; p++) begin
         if (RESET) begin
            out_sel_reg[p] <= SEL_RESET;
         end else if (sel_wr_ok && out_reg_present[p]
                      && ADDR == OUT_SEL_BASE + ADDR_W'(4 * p)) begin
            out_sel_reg[p] <= WDATA[SEL_W-1:0];
         end
      end
   end

   // ==========================================================
   // Lock, unlock sequence and one-way option
   // ==========================================================
   // Fuse word is static; sampled on every clock edge in reset, held at release
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         one_way_reg <= DEV_CFG_WORD3[ONE_WAY_BIT];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         unlock_reg <= UL_IDLE;
      end else if (unlock_wr) begin
         if (WDATA == UNLOCK_KEY_B && unlock_reg == UL_KEY_A) begin
            unlock_reg <= UL_ARMED;
         end else if (WDATA == UNLOCK_KEY_A) begin
            unlock_reg <= UL_KEY_A;
         end else begin
            unlock_reg <= UL_IDLE;
         end
      end else if (cfg_wr || (WR && unlock_reg == UL_KEY_A)) begin
         // Any write between the two keys breaks the sequence; one lock write per unlock
         unlock_reg <= UL_IDLE;
      end
   end

   // Lock write counts only while armed by a full unlock sequence
   always_comb begin
      lock_next = lock_reg;
      if (cfg_wr && unlock_reg == UL_ARMED) begin
         lock_next = WDATA[LOCK_BIT];
         if (one_way_reg && ever_locked_reg) begin
            lock_next = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         lock_reg <= LOCK_RESET;
         ever_locked_reg <= 1'b0;
      end else begin
         lock_reg <= lock_next;
         ever_locked_reg <= ever_locked_reg | lock_next;
      end
   end

   // ==========================================================
   // Input routing
   // ==========================================================
   always_comb begin
      logic [SEL_W-1:0] code;
      logic [4:0] pin;
      code = '0;
      pin = '0;
      for (int i = 0; i < NUM_IN_SEL; i++) begin
         code = in_sel_reg[i];
         pin = {rpsel_in_group(i), code[2:0]};
         // Reserved codes, absent or analog pins give the idle level
         if (!code[3] && pin_present[pin] && !PIN_ANALOG[pin]) begin
            periph_in_next[i] = pin_sync_reg[pin];
         end else begin
            periph_in_next[i] = IN_IDLE_LEVEL[i];
         end
      end
   end

   // ==========================================================
   // Output routing, independent of the input side
   // ==========================================================
   always_comb begin
      logic sel_val;
      logic sel_ok;
      sel_val = 1'b0;
      sel_ok = 1'b0;
      for (int p = 0; p < NUM_PINS; p++) begin
         sel_val = 1'b0;
         sel_ok = 1'b1;
         unique case (p / GROUP_PINS)
            0: begin
               unique case (out_sel_reg[p])
                  G1_UART2_RTS: sel_val = UART_TWO_REQUEST_TO_SEND;
                  G1_SPI1_SEL: sel_val = SPI_ONE_SELECT_OUT;
                  G1_BUS_PWR: begin
                     sel_val = BUS_POWER_ENABLE;
                     sel_ok = USB;
                  end
                  G1_CMP1: sel_val = COMPARE_ONE_OUT;
                  G1_COMPARATOR2: sel_val = COMPARATOR_TWO_OUT;
                  default: sel_ok = 1'b0;
               endcase
            end
            1: begin
               unique case (out_sel_reg[p])
                  G2_SPI1_DO: sel_val = SPI_ONE_DATA_OUT;
                  G2_SPI2_DO: sel_val = SPI_TWO_DATA_OUT;
                  G2_CMP2: sel_val = COMPARE_TWO_OUT;
                  G2_COMPARATOR3: sel_val = COMPARATOR_THREE_OUT;
                  default: sel_ok = 1'b0;
               endcase
            end
            2: begin
               unique case (out_sel_reg[p])
                  G3_SPI1_DO: sel_val = SPI_ONE_DATA_OUT;
                  G3_SPI2_DO: sel_val = SPI_TWO_DATA_OUT;
                  G3_CMP4: sel_val = COMPARE_FOUR_OUT;
                  G3_CMP5: sel_val = COMPARE_FIVE_OUT;
                  G3_REFCLK: sel_val = REFERENCE_CLOCK_OUT;
                  default: sel_ok = 1'b0;
               endcase
            end
            default: begin
               unique case (out_sel_reg[p])
                  G4_UART1_RTS: sel_val = UART_ONE_REQUEST_TO_SEND;
                  G4_UART2_TX: sel_val = UART_TWO_TRANSMIT;
                  G4_SPI2_SEL: sel_val = SPI_TWO_SELECT_OUT;
                  G4_CMP3: sel_val = COMPARE_THREE_OUT;
                  G4_COMPARATOR1: sel_val = COMPARATOR_ONE_OUT;
                  default: sel_ok = 1'b0;
               endcase
            end
         endcase
         // Remap overrides GPIO drive, but an analog pin keeps its port path
         if (sel_ok && out_reg_present[p] && !PIN_ANALOG[p]) begin
            pin_out_next[p] = sel_val;
            pin_oe_next[p] = 1'b1;
         end else begin
            pin_out_next[p] = GPIO_OUT[p];
            pin_oe_next[p] = GPIO_OE[p];
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         periph_in_reg <= IN_IDLE_LEVEL;
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
      end else begin
         periph_in_reg <= periph_in_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   // ==========================================================
   // Register read
   // ==========================================================
   // Reads have no side effect, so they never break the unlock sequence
   always_comb begin
      rdata_next = 32'h0000_0000;
      for (int i = 0; i < NUM_IN_SEL; i++) begin
         if (ADDR == IN_SEL_BASE + ADDR_W'(4 * i)) begin
            rdata_next[SEL_W-1:0] = in_sel_reg[i];
         end
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         if (ADDR == OUT_SEL_BASE + ADDR_W'(4 * p)) begin
            rdata_next[SEL_W-1:0] = out_sel_reg[p];
         end
      end
      if (ADDR == CFG_CTRL_OFS) begin
         rdata_next[LOCK_BIT] = lock_reg;
         rdata_next[ONE_WAY_BIT] = one_way_reg;
         rdata_next[ARMED_BIT] = (unlock_reg == UL_ARMED);
      end
   end

   // Data valid only in the cycle after the read strobe
   always_ff @(posedge CORE_CLK) begin
      if (RESET || !RD) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign RDATA = rdata_reg;
   assign PIN_OUT = pin_out_reg;
   assign PIN_OE = pin_oe_reg;
   assign {COMPARE_FAULT_A, SPI_TWO_SELECT, CAPTURE_TWO_IN, TIMER_FIVE_CLOCK_IN,
           EXT_IRQ_ONE, COMPARE_FAULT_B, SPI_TWO_DATA_IN, UART_TWO_CLEAR_TO_SEND,
           UART_ONE_RECEIVE, CAPTURE_FIVE_IN, CAPTURE_ONE_IN, TIMER_FOUR_CLOCK_IN,
           EXT_IRQ_TWO, SPI_ONE_DATA_IN, UART_TWO_RECEIVE, UART_ONE_CLEAR_TO_SEND,
           CAPTURE_THREE_IN, TIMER_THREE_CLOCK_IN, EXT_IRQ_THREE, REFERENCE_CLOCK_IN,
           SPI_ONE_SELECT, CAPTURE_FOUR_IN, TIMER_TWO_CLOCK_IN, EXT_IRQ_FOUR}
          = periph_in_reg;

endmodule : rpsel_crossbar

// [verification/rpsel_checker.sv]
`timescale 1ns/1ps
// ==========
// Crossbar port checks
module rpsel_checker
   import rpsel_pkg::*;
(
   // Clock, reset and bus
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [31:0] DEV_CFG_WORD3,
   // Pins
   input wire logic [NUM_PINS-1:0] PIN_IN,
   input wire logic [NUM_PINS-1:0] PIN_ANALOG,
   input wire logic [NUM_PINS-1:0] GPIO_OUT,
   input wire logic [NUM_PINS-1:0] GPIO_OE,
   input wire logic [NUM_PINS-1:0] PIN_OUT,
   input wire logic [NUM_PINS-1:0] PIN_OE,
   // One peripheral input from three groups
   input wire logic EXT_IRQ_FOUR,
   input wire logic UART_ONE_RECEIVE,
   input wire logic COMPARE_FAULT_A
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);

   logic cfg_rd_reg;
   logic held_reg;

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         cfg_rd_reg <= 1'b0;
      end else begin
         cfg_rd_reg <= RD && (ADDR == CFG_CTRL_OFS);
      end
   end

   // Seen locked with one-way set: only reset may clear it
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         held_reg <= 1'b0;
      end else if (cfg_rd_reg && RDATA[LOCK_BIT] && RDATA[ONE_WAY_BIT]) begin
         held_reg <= 1'b1;
      end
   end

   sequence s_cfg_rd;
      RD && (ADDR == CFG_CTRL_OFS);
   endsequence
   sequence s_sel_rd;
      RD && (ADDR < CFG_CTRL_OFS);
   endsequence

   AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data not zero outside read answer");
   AST_SEL_NARROW: assert property (s_sel_rd |=> RDATA[31:4] == 28'h0)
      else $error("selector wider than four bits");
   AST_ONE_WAY_RO: assert property (s_cfg_rd |=>
      RDATA[ONE_WAY_BIT] == DEV_CFG_WORD3[ONE_WAY_BIT])
      else $error("one-way option readback wrong");
   AST_ONE_WAY_HOLD: assert property (held_reg && cfg_rd_reg |-> RDATA[LOCK_BIT])
      else $error("lock cleared under one-way option");
   AST_ANALOG_GPIO: assert property (!$past(RESET) |->
      (((PIN_OE ^ $past(GPIO_OE)) | (PIN_OUT ^ $past(GPIO_OUT)))
      & $past(PIN_ANALOG)) == 32'h0)
      else $error("remap overrode analog pin");
   AST_GPIO_DRIVE_KEPT: assert property (!$past(RESET) |->
      ($past(GPIO_OE) & ~PIN_OE) == 32'h0)
      else $error("port drive dropped");
   AST_OUT_NEEDS_OE: assert property (!$past(RESET) |->
      ((PIN_OUT ^ $past(GPIO_OUT)) & ~PIN_OE) == 32'h0)
      else $error("pin value changed without drive");
   AST_IN_IDLE: assert property (PIN_IN == 32'h0 |-> ##3
      !(EXT_IRQ_FOUR || UART_ONE_RECEIVE || COMPARE_FAULT_A))
      else $error("peripheral input high with all pins low");
endmodule : rpsel_checker

bind rpsel_crossbar rpsel_checker rpsel_checker_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
   .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .DEV_CFG_WORD3(DEV_CFG_WORD3), .PIN_IN(PIN_IN),
   .PIN_ANALOG(PIN_ANALOG), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .PIN_OUT(PIN_OUT),
   .PIN_OE(PIN_OE), .EXT_IRQ_FOUR(EXT_IRQ_FOUR), .UART_ONE_RECEIVE(UART_ONE_RECEIVE),
   .COMPARE_FAULT_A(COMPARE_FAULT_A));

// [verification/rpsel_periph_model.sv]
`timescale 1ns/1ps
// ==========
// Peripherals and pin levels
module rpsel_periph_model (
   // Clock
   input wire logic clk,
   // Far side levels
   output logic [16:0] periph_out,
   output logic [31:0] pin_level
);
   logic [31:0] lfsr_reg = 32'h0000_0001;

   // New levels every cycle, so a stale route never matches by luck
   always @(posedge clk) begin
      lfsr_reg <= {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
   end
   assign periph_out = lfsr_reg[16:0] ^ lfsr_reg[31:15];
   // All pins low now and then, for the idle-level case
   assign pin_level = (lfsr_reg[3:0] == 4'h0) ? 32'h0 : {lfsr_reg[15:0], lfsr_reg[31:16]};
endmodule : rpsel_periph_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
// ==========
// Bench top
module tb_top;
   import rpsel_pkg::*;
   logic CORE_CLK = 1'b0;
   logic RESET = 1'b1;
   logic [ADDR_W-1:0] ADDR = '0;
   logic [31:0] WDATA = '0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] DEV_CFG_WORD3 = '0;
   logic [31:0] PIN_ANALOG = '0;
   logic [31:0] GPIO_OUT = '0;
   logic [31:0] GPIO_OE = '0;
   logic pin_chk = 1'b0;
   wire [31:0] RDATA, PIN_IN, PIN_OUT, PIN_OE;
   wire [16:0] periph;
   wire [23:0] ins;
   int failures = 0;
   int tests_run = 0;
   logic [31:0] rd_exp [$];
   logic [3:0] in_m [24];
   logic [3:0] out_m [32];
   logic lock_m, held_m, ow_m, rd_q, chk_q;
   logic [31:0] gv, ov, av, h1, h2, h3;
   logic [16:0] pv;
   int route [4][8] = '{'{-1, -1, 1, 3, -1, 8, -1, 14}, '{-1, -1, -1, 5, 6, 9, -1, 15},
      '{-1, -1, -1, 5, 6, 11, 12, 16}, '{-1, 0, 2, -1, 4, 10, -1, 13}};

   rpsel_crossbar rpsel_crossbar_inst (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DEV_CFG_WORD3(DEV_CFG_WORD3),
      .PIN_IN(PIN_IN), .PIN_ANALOG(PIN_ANALOG), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
      .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .UART_ONE_REQUEST_TO_SEND(periph[0]),
      .UART_TWO_REQUEST_TO_SEND(periph[1]), .UART_TWO_TRANSMIT(periph[2]),
      .SPI_ONE_SELECT_OUT(periph[3]), .SPI_TWO_SELECT_OUT(periph[4]),
      .SPI_ONE_DATA_OUT(periph[5]), .SPI_TWO_DATA_OUT(periph[6]), .BUS_POWER_ENABLE(periph[7]),
      .COMPARE_ONE_OUT(periph[8]), .COMPARE_TWO_OUT(periph[9]), .COMPARE_THREE_OUT(periph[10]),
      .COMPARE_FOUR_OUT(periph[11]), .COMPARE_FIVE_OUT(periph[12]),
      .COMPARATOR_ONE_OUT(periph[13]), .COMPARATOR_TWO_OUT(periph[14]),
      .COMPARATOR_THREE_OUT(periph[15]), .REFERENCE_CLOCK_OUT(periph[16]),
      .EXT_IRQ_FOUR(ins[0]), .TIMER_TWO_CLOCK_IN(ins[1]), .CAPTURE_FOUR_IN(ins[2]),
      .SPI_ONE_SELECT(ins[3]), .REFERENCE_CLOCK_IN(ins[4]), .EXT_IRQ_THREE(ins[5]),
      .TIMER_THREE_CLOCK_IN(ins[6]), .CAPTURE_THREE_IN(ins[7]), .UART_ONE_CLEAR_TO_SEND(ins[8]),
      .UART_TWO_RECEIVE(ins[9]), .SPI_ONE_DATA_IN(ins[10]), .EXT_IRQ_TWO(ins[11]),
      .TIMER_FOUR_CLOCK_IN(ins[12]), .CAPTURE_ONE_IN(ins[13]), .CAPTURE_FIVE_IN(ins[14]),
      .UART_ONE_RECEIVE(ins[15]), .UART_TWO_CLEAR_TO_SEND(ins[16]), .SPI_TWO_DATA_IN(ins[17]),
      .COMPARE_FAULT_B(ins[18]), .EXT_IRQ_ONE(ins[19]), .TIMER_FIVE_CLOCK_IN(ins[20]),
      .CAPTURE_TWO_IN(ins[21]), .SPI_TWO_SELECT(ins[22]), .COMPARE_FAULT_A(ins[23]));
   rpsel_periph_model rpsel_periph_model_inst (.clk(CORE_CLK), .periph_out(periph),
      .pin_level(PIN_IN));

   initial begin
      forever #2.5 CORE_CLK = ~CORE_CLK;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // Pre-edge copies: what the design saw at the last edge
   always @(posedge CORE_CLK) begin
      gv <= GPIO_OUT;
      ov <= GPIO_OE;
      av <= PIN_ANALOG;
      pv <= periph;
      h1 <= PIN_IN;
      h2 <= h1;
      h3 <= h2;
      rd_q <= RD;
      chk_q <= pin_chk;
   end

   always @(negedge CORE_CLK) begin : mon
      int k;
      int g;
      logic [3:0] c;
      if (rd_q) check(RDATA, rd_exp.pop_front());
      if (chk_q) begin
         for (int p = 0; p < 32; p++) begin
            k = (av[p] || NO_OUT_REG_MASK[p] || out_m[p][3]) ? -1 : route[p / 8][out_m[p][2:0]];
            check({PIN_OE[p], PIN_OUT[p]},
               (k < 0) ? {ov[p], gv[p]} : {1'b1, pv[k]});
         end
         for (int i = 0; i < 24; i++) begin
            c = in_m[i];
            g = (i < 5) ? 0 : (i < 11) ? 8 : (i < 19) ? 16 : 24;
            check(ins[i],
               (!c[3] && !av[g + c[2:0]]) ? h3[g + c[2:0]] : 1'b0);
         end
      end
   end

   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= w;
      RD <= !w;
      @(posedge CORE_CLK);
   endtask : bus

   task automatic idle(input int n);
      WR <= 1'b0;
      RD <= 1'b0;
      repeat (n) @(posedge CORE_CLK);
   endtask : idle

   function automatic logic [9:0] sel_addr(input int i);
      return (i < 24) ? IN_SEL_BASE + 10'(4 * i) : OUT_SEL_BASE + 10'(4 * (i - 24));
   endfunction : sel_addr

   function automatic logic [31:0] cfg_exp(input logic armed);
      return (32'(ow_m) << ONE_WAY_BIT) | (32'(lock_m) << LOCK_BIT) | 32'(armed);
   endfunction : cfg_exp

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      rd_exp.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic wsel(input int i, input logic [31:0] d);
      if (!lock_m && i < 24) in_m[i] = d[3:0];
      if (!lock_m && i >= 24 && !NO_OUT_REG_MASK[i - 24]) out_m[i - 24] = d[3:0];
      bus(1'b1, sel_addr(i), d);
   endtask : wsel

   task automatic all_sel(input int r, input logic check_only);
      for (int i = 0; i < 56; i++) begin
         if (!check_only) wsel(i, {28'($urandom), 4'((r + i) % 16)});
      end
      for (int i = 0; i < 56; i++) begin
         rd(sel_addr(i), (i < 24) ? in_m[i] : out_m[i - 24]);
      end
   endtask : all_sel

   task automatic set_lock(input logic v);
      bus(1'b1, UNLOCK_OFS, UNLOCK_KEY_A);
      bus(1'b1, UNLOCK_OFS, UNLOCK_KEY_B);
      rd(CFG_CTRL_OFS, cfg_exp(1'b1));
      bus(1'b1, CFG_CTRL_OFS, 32'(v) << LOCK_BIT);
      if (!held_m) lock_m = v;
      held_m = ow_m && lock_m;
      rd(CFG_CTRL_OFS, cfg_exp(1'b0));
   endtask : set_lock

   // Selectors are written before any pin is looked at
   task automatic phase(input int n);
      idle(1);
      PIN_ANALOG <= $urandom & $urandom;
      idle(4);
      pin_chk <= 1'b1;
      repeat (n) begin
         GPIO_OUT <= $urandom;
         GPIO_OE <= $urandom;
         @(posedge CORE_CLK);
      end
      pin_chk <= 1'b0;
      idle(2);
   endtask : phase

   task automatic do_reset(input logic ow);
      ow_m = ow;
      DEV_CFG_WORD3 <= 32'(ow) << ONE_WAY_BIT;
      RESET <= 1'b1;
      idle(10);
      RESET <= 1'b0;
      lock_m = LOCK_RESET;
      held_m = 1'b0;
      foreach (in_m[i]) in_m[i] = SEL_RESET;
      foreach (out_m[i]) out_m[i] = SEL_RESET;
   endtask : do_reset

   initial begin
      void'($urandom(40));
      do_reset(1'b0);
      all_sel(0, 1'b1);
      rd(CFG_CTRL_OFS, cfg_exp(1'b0));
      rd(10'h3FC, 32'h0);
      for (int r = 0; r < 16; r++) begin
         all_sel(r, 1'b0);
         phase(20);
      end
      bus(1'b1, CFG_CTRL_OFS, 32'h0000_2000);
      bus(1'b1, UNLOCK_OFS, UNLOCK_KEY_A);
      wsel(24, 32'h0000_0005);
      bus(1'b1, UNLOCK_OFS, UNLOCK_KEY_B);
      bus(1'b1, CFG_CTRL_OFS, 32'h0000_2000);
      rd(CFG_CTRL_OFS, cfg_exp(1'b0));
      set_lock(1'b1);
      all_sel(3, 1'b0);
      phase(16);
      set_lock(1'b0);
      all_sel(5, 1'b0);
      do_reset(1'b1);
      rd(CFG_CTRL_OFS, cfg_exp(1'b0));
      set_lock(1'b1);
      set_lock(1'b0);
      all_sel(7, 1'b0);
      do_reset(1'b1);
      all_sel(9, 1'b0);
      phase(12);
      test_done();
   end

   initial begin
      #(20000 * 5);
      failures++;
      test_done();
   end
endmodule : tb_top
